// >>> include/ccr_pkg.sv
// constants and carrier types for the channel 1 configuration and calibration registers
package ccr_pkg;

  // register indices; the byte address is four times the index
  localparam logic [5:0] CCR_IDX_CONFIG      = 6'h0E;
  localparam logic [5:0] CCR_IDX_OFFSET_HIGH = 6'h0F;
  localparam logic [5:0] CCR_IDX_OFFSET_LOW  = 6'h10;
  localparam logic [5:0] CCR_IDX_GAIN_HIGH   = 6'h11;
  localparam logic [5:0] CCR_IDX_GAIN_LOW    = 6'h12;
  localparam logic [5:0] CCR_IDX_STATUS      = 6'h20;

  // storage entries held in the register array
  localparam int CCR_NUM_REGS     = 5;
  localparam int CCR_ENT_CONFIG   = 0;
  localparam int CCR_ENT_OFF_HIGH = 1;
  localparam int CCR_ENT_OFF_LOW  = 2;
  localparam int CCR_ENT_GAIN_HI  = 3;
  localparam int CCR_ENT_GAIN_LO  = 4;

  // values after reset, per entry
  localparam logic [15:0] CCR_RESET [CCR_NUM_REGS] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  // writable bits, per entry; the rest read as zero
  localparam logic [15:0] CCR_WMASK [CCR_NUM_REGS] = '{16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};

  // configuration register field positions
  localparam int CCR_PHASE_MSB = 15;
  localparam int CCR_PHASE_LSB = 6;
  localparam int CCR_DCOFF_BIT = 2;
  localparam int CCR_SEL_MSB   = 1;
  localparam int CCR_SEL_LSB   = 0;
  // low calibration registers keep their field in the upper byte
  localparam int CCR_LOW_MSB   = 15;
  localparam int CCR_LOW_LSB   = 8;

  // input selector codes
  localparam logic [1:0] CCR_SEL_PINS     = 2'h0;
  localparam logic [1:0] CCR_SEL_SHORTED  = 2'h1;
  localparam logic [1:0] CCR_SEL_TEST_POS = 2'h2;
  localparam logic [1:0] CCR_SEL_TEST_NEG = 2'h3;

  // status register field positions
  localparam int CCR_STAT_ROUTE_LSB = 0;
  localparam int CCR_STAT_DC_ON_BIT = 4;

  // one-hot routing of the channel 1 modulator input
  typedef struct packed {
    logic test_neg;
    logic test_pos;
    logic shorted;
    logic pins;
  } ccr_route_t;

  // configuration register as seen by software
  typedef struct packed {
    logic [9:0] phase;
    logic [2:0] reserved;
    logic       dc_off;
    logic [1:0] sel;
  } ccr_config_t;

endpackage

// >>> hw/ccr_reg16.sv
// one 16-bit software register with a write mask and byte-lane strobes
`timescale 1ns/1ps
module ccr_reg16 #(
  parameter logic [15:0] RESET_VAL  = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // write request
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_strb,
  input  wire logic [15:0] wr_data,
  // stored value
  output logic      [15:0] q
);

  logic [15:0] lane_mask;
  logic [15:0] next_q;

  // only bits that are writable and whose byte lane is strobed change
  always_comb begin
    lane_mask = WRITE_MASK & {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    next_q    = (q & ~lane_mask) | (wr_data & lane_mask);
  end

  // storage; reserved bits keep their reset value of zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= next_q;
    end
  end

endmodule

// >>> hw/ccr_chan1_regs.sv
// apb register bank for channel 1 phase, dc filter, input selection and calibration
`timescale 1ns/1ps
// Functional notes
// (R1) phase delay is 10-bit two's complement in config bits 15:6, modulator clocks
// (R2) config register at index 0x0E, resets to zero
// (R3) config bit 2 clear follows the global dc filter, set bypasses it
// (R4) selector 00 routes own input pair, 01 shorts the inputs
// (R5) selector 10 routes positive dc test signal, 11 the negative one
// (R6) offset bits 23:8 fill offset-high at index 0x0F, reset zero
// (R7) offset-low at 0x10 holds offset bits 7:0 in 15:8, low byte reads zero
// (R8) gain bits 23:8 fill gain-high at index 0x11
// (R9) gain-high resets to 0x8000, gain-low resets to zero
// (R10) gain-low at 0x12 holds gain bits 7:0 in 15:8, low byte reads zero
// (R11) config bits 5:3 read zero and ignore writes
module ccr_chan1_regs
  import ccr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // global dc filter control from the device core
  input  wire logic [3:0]        global_dc_filter_setting,
  // channel 1 datapath controls
  output logic      [9:0]        chan1_phase_delay,
  output logic                   chan1_dc_filter_off,
  output logic      [3:0]        chan1_dc_filter_code,
  output logic                   chan1_dc_filter_on,
  output logic      [1:0]        chan1_input_select,
  output ccr_route_t             chan1_route,
  output logic      [23:0]       chan1_offset_cal,
  output logic      [23:0]       chan1_gain_cal
);

  // register array and decode results
  logic [15:0]                     regs [CCR_NUM_REGS];
  logic [CCR_NUM_REGS-1:0]         hit_vec;
  logic                            hit_store;
  logic                            hit_status;
  logic                            addr_ok;
  logic [ADDR_W-3:0]               index;
  logic                            setup_phase;
  logic                            write_commit;
  logic [15:0]                     read_word;
  logic [15:0]                     status_word;
  ccr_config_t                     cfg;
  ccr_route_t                      next_route;
  logic [3:0]                      next_dc_code;

  assign index       = paddr[ADDR_W-1:2];
  assign setup_phase = psel && !penable;
  assign cfg         = ccr_config_t'(regs[CCR_ENT_CONFIG]);

  // address decode: word aligned, then one entry by index
  always_comb begin
    hit_vec    = '0;
    hit_status = 1'b0;
    addr_ok    = (paddr[1:0] == 2'h0);
    if (!addr_ok) begin
      hit_vec = '0;
    end else if ({2'b00, index} == {{(ADDR_W-6){1'b0}}, CCR_IDX_CONFIG}) begin
      hit_vec[CCR_ENT_CONFIG] = 1'b1;                           // see (R2)
    end else if ({2'b00, index} == {{(ADDR_W-6){1'b0}}, CCR_IDX_OFFSET_HIGH}) begin
      hit_vec[CCR_ENT_OFF_HIGH] = 1'b1;                         // see (R6)
    end else if ({2'b00, index} == {{(ADDR_W-6){1'b0}}, CCR_IDX_OFFSET_LOW}) begin
      hit_vec[CCR_ENT_OFF_LOW] = 1'b1;                          // see (R7)
    end else if ({2'b00, index} == {{(ADDR_W-6){1'b0}}, CCR_IDX_GAIN_HIGH}) begin
      hit_vec[CCR_ENT_GAIN_HI] = 1'b1;                          // see (R8)
    end else if ({2'b00, index} == {{(ADDR_W-6){1'b0}}, CCR_IDX_GAIN_LOW}) begin
      hit_vec[CCR_ENT_GAIN_LO] = 1'b1;                          // see (R10)
    end else if ({2'b00, index} == {{(ADDR_W-6){1'b0}}, CCR_IDX_STATUS}) begin
      hit_status = 1'b1;
    end
    hit_store = |hit_vec;
  end

  // a write lands only at the access edge on which pready is seen high
  assign write_commit = psel && penable && pready && pwrite;

  // storage entries; reserved bits are masked off inside each entry
  genvar gi;
  generate
    for (gi = 0; gi < CCR_NUM_REGS; gi++) begin : g_reg
      ccr_reg16 #(
        .RESET_VAL  (CCR_RESET[gi]),                            // see (R9)
        .WRITE_MASK (CCR_WMASK[gi])                             // see (R11)
      ) u_reg (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (write_commit && hit_vec[gi]),
        .wr_strb (pstrb[1:0]),
        .wr_data (pwdata[15:0]),
        .q       (regs[gi])
      );
    end
  endgenerate

  // status word shows the live routing and dc filter state
  always_comb begin
    status_word                                           = 16'h0000;
    status_word[CCR_STAT_ROUTE_LSB +: 4]                  = chan1_route;
    status_word[CCR_STAT_DC_ON_BIT]                       = chan1_dc_filter_on;
  end

  // read mux; reserved bits already hold zero in storage
  always_comb begin
    read_word = 16'h0000;
    for (int i = 0; i < CCR_NUM_REGS; i++) begin
      if (hit_vec[i]) begin
        read_word = regs[i] & CCR_WMASK[i];                     // see (R7) (R10) (R11)
      end
    end
    if (hit_status) begin
      read_word = status_word;
    end
  end

  // answer one cycle after setup: pready rises for the access phase only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // read data and error are prepared during setup and held through access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
      pslverr <= !(hit_store || hit_status);                   // unmapped or misaligned
    end else if (pready) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // input selector decoded to one routing switch
  always_comb begin
    next_route = '0;
    case (cfg.sel)
      CCR_SEL_PINS:     next_route.pins     = 1'b1;             // see (R4)
      CCR_SEL_SHORTED:  next_route.shorted  = 1'b1;             // see (R4)
      CCR_SEL_TEST_POS: next_route.test_pos = 1'b1;             // see (R5)
      default:          next_route.test_neg = 1'b1;             // see (R5)
    endcase
  end

  // channel follows the global filter setting unless bypassed
  always_comb begin
    next_dc_code = cfg.dc_off ? 4'h0 : global_dc_filter_setting; // see (R3)
  end

  // routing and dc filter outputs, one cycle behind the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_route          <= '0;
      chan1_dc_filter_code <= 4'h0;
      chan1_dc_filter_on   <= 1'b0;
    end else begin
      chan1_route          <= next_route;
      chan1_dc_filter_code <= next_dc_code;
      chan1_dc_filter_on   <= |next_dc_code;                   // see (R3)
    end
  end

  // direct field views of the stored registers
  assign chan1_phase_delay   = regs[CCR_ENT_CONFIG][CCR_PHASE_MSB:CCR_PHASE_LSB];   // see (R1)
  assign chan1_dc_filter_off = regs[CCR_ENT_CONFIG][CCR_DCOFF_BIT];                 // see (R3)
  assign chan1_input_select  = regs[CCR_ENT_CONFIG][CCR_SEL_MSB:CCR_SEL_LSB];       // see (R4)
  // 24-bit calibration words join high register and upper byte of low register
  assign chan1_offset_cal = {regs[CCR_ENT_OFF_HIGH], regs[CCR_ENT_OFF_LOW][CCR_LOW_MSB:CCR_LOW_LSB]}; // see (R6)
  assign chan1_gain_cal   = {regs[CCR_ENT_GAIN_HI], regs[CCR_ENT_GAIN_LO][CCR_LOW_MSB:CCR_LOW_LSB]};  // see (R8)

endmodule

// >>> sim/ccr_chan1_regs_properties.sv
// concurrent checks on the ports of the channel 1 register bank
`timescale 1ns/1ps
module ccr_chan1_props
  import ccr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // apb slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  // datapath controls
  input wire logic [3:0]        global_dc_filter_setting,
  input wire logic [9:0]        chan1_phase_delay,
  input wire logic              chan1_dc_filter_off,
  input wire logic [3:0]        chan1_dc_filter_code,
  input wire logic [1:0]        chan1_input_select,
  input wire ccr_route_t        chan1_route,
  input wire logic [23:0]       chan1_offset_cal,
  input wire logic [23:0]       chan1_gain_cal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a committing write
  logic wr;
  assign wr = psel && penable && pready && pwrite;

  property p_phase;
    wr && paddr == ADDR_W'(8'h38) && pstrb[1:0] == 2'b11 |=> chan1_phase_delay == $past(pwdata[15:6])
      && chan1_input_select == $past(pwdata[1:0]) && chan1_dc_filter_off == $past(pwdata[2]);
  endproperty
  a_phase: assert property (p_phase) else $error("config fields not taken from write");
  property p_off_hi;
    wr && paddr == ADDR_W'(8'h3C) && pstrb[1:0] == 2'b11 |=> chan1_offset_cal[23:8] == $past(pwdata[15:0]);
  endproperty
  a_off_hi: assert property (p_off_hi) else $error("offset upper bits wrong");
  property p_off_lo;
    wr && paddr == ADDR_W'(8'h40) && pstrb[1] |=> chan1_offset_cal[7:0] == $past(pwdata[15:8]);
  endproperty
  a_off_lo: assert property (p_off_lo) else $error("offset lower bits wrong");
  property p_gain_hi;
    wr && paddr == ADDR_W'(8'h44) && pstrb[1:0] == 2'b11 |=> chan1_gain_cal[23:8] == $past(pwdata[15:0]);
  endproperty
  a_gain_hi: assert property (p_gain_hi) else $error("gain upper bits wrong");
  property p_gain_lo;
    wr && paddr == ADDR_W'(8'h48) && pstrb[1] |=> chan1_gain_cal[7:0] == $past(pwdata[15:8]);
  endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain lower bits wrong");
  // routing and dc code lag by one edge, so the edge that leaves reset is skipped
  property p_route;
    $past(rst_n) |=> chan1_route == ccr_route_t'(4'h1 << $past(chan1_input_select));
  endproperty
  a_route: assert property (p_route) else $error("input routing does not follow selector");
  property p_dc;
    $past(rst_n) |=> chan1_dc_filter_code == ($past(chan1_dc_filter_off) ? 4'h0 : $past(global_dc_filter_setting));
  endproperty
  a_dc: assert property (p_dc) else $error("dc filter code wrong");
  property p_rsvd;
    pready && !pwrite && paddr inside {ADDR_W'(8'h38), ADDR_W'(8'h40), ADDR_W'(8'h48)}
      |-> (prdata[7:0] & (paddr == ADDR_W'(8'h38) ? 8'h38 : 8'hFF)) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_reset;
    $rose(rst_n) |-> chan1_gain_cal == 24'h800000 && chan1_offset_cal == 24'h0 && chan1_phase_delay == 10'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("calibration reset values wrong");
endmodule

bind ccr_chan1_regs ccr_chan1_props #(.ADDR_W(ADDR_W)) ccr_chan1_props_i (.*);

// >>> sim/ccr_chan1_regs_bench.sv
// self-checking bench for the channel 1 register bank
`timescale 1ns/1ps
module ccr_chan1_regs_bench
  import ccr_pkg::*;
;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, dc_off, dc_on;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, d;
  logic [3:0]  pstrb = 4'h0, gdc = 4'h0, dc_code;
  logic [9:0]  phase;
  logic [1:0]  sel;
  ccr_route_t  route;
  logic [23:0] ocal, gcal;
  logic [15:0] mdl [5];
  logic        e;
  int          seed = 32'h8750, err_count = 0, samples_checked = 0;

  ccr_chan1_regs ccr_chan1_regs_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .global_dc_filter_setting(gdc), .chan1_phase_delay(phase), .chan1_dc_filter_off(dc_off),
    .chan1_dc_filter_code(dc_code), .chan1_dc_filter_on(dc_on), .chan1_input_select(sel),
    .chan1_route(route), .chan1_offset_cal(ocal), .chan1_gain_cal(gcal));

  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  // compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // writable bits per register
  function automatic logic [15:0] wmask(input int i);
    return (i == 0) ? 16'hFFC7 : (i == 2 || i == 4) ? 16'hFF00 : 16'hFFFF;
  endfunction
  // write, read back, and check every datapath output
  task automatic step(input int i, input logic [15:0] wd, input logic [3:0] s);
    logic [15:0] m;
    m = wmask(i) & {{8{s[1]}}, {8{s[0]}}};
    @(posedge clk);
    gdc <= 4'($random(seed));
    apb(1'b1, 8'h38 + 8'(i * 4), {16'($random(seed)), wd}, s);
    mdl[i] = (mdl[i] & ~m) | (wd & m);
    apb(1'b0, 8'h38 + 8'(i * 4), 32'h0, 4'h0);
    chk(r, {16'h0, mdl[i]});
    chk({31'h0, e}, 32'h0);
    @(negedge clk);
    chk(phase, mdl[0][15:6]);
    chk({sel, dc_off}, {mdl[0][1:0], mdl[0][2]});
    chk(ocal, {mdl[1], mdl[2][15:8]});
    chk(gcal, {mdl[3], mdl[4][15:8]});
    chk(dc_code, mdl[0][2] ? 4'h0 : gdc);
    chk({31'h0, dc_on}, {31'h0, !mdl[0][2] && gdc != 4'h0});
    chk(route, 4'h1 << mdl[0][1:0]);
  endtask
  // verdict
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  // main sequence
  initial begin
    // second pass starts with a reset in mid-run after the registers were written
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      mdl = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
        apb(1'b0, 8'h38 + 8'(i * 4), 32'h0, 4'h0);
        chk(r, {16'h0, mdl[i]});
      end
      for (int k = 0; k < 8; k++) begin
        d = $random(seed);
        step(0, {d[15:3], 3'(k)}, 4'h3);
      end
      for (int j = 0; j < 60; j++) begin
        d = $random(seed);
        step(int'($unsigned($random(seed)) % 5), d[15:0], 4'($random(seed)));
      end
    end
    // unmapped index answers with an error and reads zero
    apb(1'b0, 8'h4C, 32'h0, 4'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    // misaligned write is refused and leaves the config register alone
    apb(1'b1, 8'h39, 32'h0000_FFFF, 4'h3);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h38, 32'h0, 4'h0);
    chk(r, {16'h0, mdl[0]});
    // status word mirrors routing and dc filter state
    apb(1'b0, 8'h80, 32'h0, 4'h0);
    chk(r, {27'h0, !mdl[0][2] && gdc != 4'h0, 4'h1 << mdl[0][1:0]});
    chk({31'h0, e}, 32'h0);
    summarize();
  end
endmodule
